// file: dapc_map.vh
// Purpose: Constants of the dual converter output and power control block
// Assumes: Included by dapc_top.v only
// Notes: Register address is the serial-port address of the output mode register
`ifndef DAPC_MAP_VH
`define DAPC_MAP_VH

// Register map
`define DAPC_ADDR_W 13
`define DAPC_OUT_MODE_ADDR 13'h014
`define DAPC_OUT_MODE_RST 8'h00
`define DAPC_OM_TRI_A 0
`define DAPC_OM_TRI_B 1

// Serial-port power modes
`define DAPC_PM_RUN 2'h0
`define DAPC_PM_DOWN 2'h1
`define DAPC_PM_STBY 2'h2

// Serial-port output codings
`define DAPC_FMT_OB 2'h0
`define DAPC_FMT_TC 2'h1
`define DAPC_FMT_GRAY 2'h2

// Data path
`define DAPC_BITS 11
`define DAPC_WORD_W 24
`define DAPC_LATENCY 5'h0c
`define DAPC_FIFO_DEPTH 16
`define DAPC_FIFO_AW 4

`endif

// file: dapc_top.v
// Purpose: Power state, three-state and output coding control of a dual 11-bit converter
// Assumes: mclk at 20 MHz, sample clock far slower and sampled as a plain input
// Notes: The converter core delivers offset binary codes, already saturated
`timescale 1ns/1ns
`include "dapc_map.vh"

// Sample delay buffer; pushes and pops in one cycle when full-level is steady
module dapc_fifo #(
    parameter W = 24,
    parameter D = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire mclk,
    input wire srst,
    input wire flush,
    // Filling side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Draining side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data,
    // Fill level
    output wire [AW:0] count
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign pop = out_valid && out_ready;
    // A pop in the same cycle frees the slot, so a full buffer still accepts
    assign in_ready = (cnt_r != D[AW:0]) || pop;
    assign push = in_valid && in_ready;
    assign out_data = mem[rp_r];
    assign count = cnt_r;

    always @(posedge mclk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always @(posedge mclk) begin
        if (srst || flush) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // dapc_fifo

// Overview of operation
// R1 - Power-down entered on pin or serial request
// R2 - Power-down three-states every output driver
// R3 - Pin driven low resumes normal conversion
// R4 - Serial standby keeps reference powered
// R5 - Pin mode: format pin selects OB/TC
// R6 - Pin mode: stabilizer pin disables/enables stabilizer
// R7 - Serial mode: offset binary, twos, gray
// R8 - Output-disable pin low enables data drivers
// R9 - Output-disable pin high three-states data drivers
// R10 - Controller must not toggle disable rapidly
// R11 - Register bit three-states each channel separately
// R12 - Sample appears twelve sample clocks later
// R13 - Outputs update after each sample rising edge
// R14 - Two forwarded data clocks accompany data
// R15 - Data valid at forwarded clock rising edge
// R16 - Offset binary codes 000,400,7ff
// R17 - Twos complement saturates, overrange flag passed
// R18 - Four fast-level pins per channel, same three-state
// R19 - Either power-down source alone powers down
module dapc_top (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Pins from outside
    input wire sample_clk,
    input wire power_down_request,
    input wire serial_clock_or_format_select_pin,
    input wire serial_io_or_stabilizer_select_pin,
    input wire monitor_out_or_output_disable_pin,
    // Converter core results
    input wire [10:0] core_code_a,
    input wire core_or_a,
    input wire [3:0] core_fast_a,
    input wire [10:0] core_code_b,
    input wire core_or_b,
    input wire [3:0] core_fast_b,
    // Serial-port decoded controls
    input wire serial_mode,
    input wire [1:0] serial_power_mode,
    input wire [1:0] serial_format,
    input wire serial_dco_invert,
    // Register access from the serial-port decoder
    input wire reg_wr,
    input wire [12:0] reg_addr,
    input wire [7:0] reg_wdata,
    output wire [7:0] reg_rdata,
    // Channel A outputs
    output wire [10:0] data_a,
    output wire data_a_oe,
    output wire or_a,
    output wire [3:0] fast_level_outputs_a,
    output wire fast_a_oe,
    // Channel B outputs
    output wire [10:0] data_b,
    output wire data_b_oe,
    output wire or_b,
    output wire [3:0] fast_level_outputs_b,
    output wire fast_b_oe,
    // Forwarded data clocks
    output wire forwarded_data_clock_a,
    output wire forwarded_data_clock_b,
    output wire dco_oe,
    // Core power and clock controls
    output wire duty_cycle_stabilizer,
    output wire reference_on,
    output wire core_on,
    output wire [2:0] power_state
);
    localparam [2:0] ST_RUN = 3'h1;
    localparam [2:0] ST_STBY = 3'h2;
    localparam [2:0] ST_DOWN = 3'h4;

    // Coding of one offset binary code per selected format
    function [10:0] dapc_encode;
        input [10:0] code;
        input twos;
        input gray;
        begin
            if (gray) begin
                dapc_encode = code ^ {1'b0, code[10:1]};
            end else if (twos) begin
                dapc_encode = {~code[10], code[9:0]};
            end else begin
                dapc_encode = code;
            end
        end
    endfunction

    // Two-stage synchronisers; stage one is read only by stage two
    reg [4:0] pin_s1_r;
    reg [4:0] pin_s2_r;
    reg [31:0] core_s1_r;
    reg [31:0] core_s2_r;
    reg sclk_d_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [7:0] out_mode_r;
    reg [10:0] data_a_r;
    reg [10:0] data_b_r;
    reg or_a_r;
    reg or_b_r;
    reg [3:0] fast_a_r;
    reg [3:0] fast_b_r;
    reg dco_r;
    reg twos_r;
    reg gray_r;
    reg dcs_r;

    wire sclk_s = pin_s2_r[0];
    wire pd_pin_s = pin_s2_r[1];
    wire fmt_pin_s = pin_s2_r[2];
    wire dcs_pin_s = pin_s2_r[3];
    wire oe_pin_s = pin_s2_r[4];
    wire sample_stb = sclk_s && !sclk_d_r;
    wire running = (state_r == ST_RUN);
    wire serial_pd = serial_mode && (serial_power_mode == `DAPC_PM_DOWN);
    wire serial_sb = serial_mode && (serial_power_mode == `DAPC_PM_STBY);
    wire pd_any = pd_pin_s || serial_pd; // [R19]

    // Delay buffer signals
    wire [23:0] fifo_in;
    wire [23:0] fifo_out;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [4:0] fifo_count;
    wire fifo_pop;
    wire fifo_push;

    // Synchronisers run through reset: a pin already high at release must not look like an edge
    always @(posedge mclk) begin
        pin_s1_r <= {monitor_out_or_output_disable_pin, serial_io_or_stabilizer_select_pin,
                     serial_clock_or_format_select_pin, power_down_request, sample_clk};
        pin_s2_r <= pin_s1_r;
        core_s1_r <= {core_fast_b, core_or_b, core_code_b, core_fast_a, core_or_a, core_code_a};
        core_s2_r <= core_s1_r;
        sclk_d_r <= sclk_s;
    end

    // Power state machine
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (pd_any) begin
                    state_nxt = ST_DOWN; // [R1]
                end else if (serial_sb) begin
                    state_nxt = ST_STBY; // [R4]
                end
            end
            ST_STBY: begin
                if (pd_any) begin
                    state_nxt = ST_DOWN;
                end else if (!serial_sb) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_DOWN: begin
                if (!pd_any) begin
                    state_nxt = serial_sb ? ST_STBY : ST_RUN; // [R3]
                end
            end
            default: begin
                state_nxt = ST_DOWN;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (srst) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Output mode register
    always @(posedge mclk) begin
        if (srst) begin
            out_mode_r <= `DAPC_OUT_MODE_RST;
        end else if (reg_wr && (reg_addr == `DAPC_OUT_MODE_ADDR)) begin
            out_mode_r <= reg_wdata;
        end
    end
    assign reg_rdata = (reg_addr == `DAPC_OUT_MODE_ADDR) ? out_mode_r : 8'h00;

    // Format and stabilizer selection; pin straps are followed live
    always @(posedge mclk) begin
        if (srst) begin
            twos_r <= 1'b0;
            gray_r <= 1'b0;
            dcs_r <= 1'b1;
        end else if (serial_mode) begin
            twos_r <= (serial_format == `DAPC_FMT_TC); // [R7]
            gray_r <= (serial_format == `DAPC_FMT_GRAY); // [R7]
            dcs_r <= 1'b1;
        end else begin
            twos_r <= fmt_pin_s; // [R5]
            gray_r <= 1'b0;
            dcs_r <= dcs_pin_s; // [R6]
        end
    end

    // Twelve-sample delay: pop only once the buffer holds the latency depth
    assign fifo_in = {core_s2_r[27:16], core_s2_r[11:0]};
    assign fifo_push = sample_stb && running;
    assign fifo_pop = fifo_push && (fifo_count >= `DAPC_LATENCY); // [R12]

    dapc_fifo #(
        .W(`DAPC_WORD_W),
        .D(`DAPC_FIFO_DEPTH),
        .AW(`DAPC_FIFO_AW)
    ) u_delay (
        .mclk(mclk),
        .srst(srst),
        .flush(!running),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out),
        .count(fifo_count)
    );

    // Output registers load on the sample clock rising edge
    always @(posedge mclk) begin
        if (srst) begin
            data_a_r <= 11'h000;
            data_b_r <= 11'h000;
            or_a_r <= 1'b0;
            or_b_r <= 1'b0;
            fast_a_r <= 4'h0;
            fast_b_r <= 4'h0;
        end else if (!running) begin
            data_a_r <= 11'h000;
            data_b_r <= 11'h000;
            or_a_r <= 1'b0;
            or_b_r <= 1'b0;
            fast_a_r <= 4'h0;
            fast_b_r <= 4'h0;
        end else if (sample_stb) begin // [R13]
            // Fast level bits bypass the long pipeline on purpose
            fast_a_r <= core_s2_r[15:12]; // [R18]
            fast_b_r <= core_s2_r[31:28]; // [R18]
            if (fifo_pop && fifo_out_valid && fifo_in_ready) begin
                data_a_r <= dapc_encode(fifo_out[10:0], twos_r, gray_r); // [R16] [R17]
                or_a_r <= fifo_out[11]; // [R17]
                data_b_r <= dapc_encode(fifo_out[22:12], twos_r, gray_r); // [R16] [R17]
                or_b_r <= fifo_out[23]; // [R17]
            end
        end
    end

    // Forwarded clock rises mid-sample, away from the data change; with serial_dco_invert set in serial mode it falls mid-sample instead
    always @(posedge mclk) begin
        if (srst) begin
            dco_r <= 1'b0;
        end else begin
            dco_r <= (~sclk_s) ^ (serial_mode && serial_dco_invert); // [R14] [R15]
        end
    end

    // Three-state control; the disable pin is meant for slow use only [R10]
    wire drv_on = running && !oe_pin_s; // [R2] [R8] [R9]
    assign data_a_oe = drv_on && !out_mode_r[`DAPC_OM_TRI_A]; // [R11]
    assign data_b_oe = drv_on && !out_mode_r[`DAPC_OM_TRI_B]; // [R11]
    assign fast_a_oe = data_a_oe; // [R18]
    assign fast_b_oe = data_b_oe; // [R18]
    assign dco_oe = running; // [R2]

    assign data_a = data_a_r;
    assign data_b = data_b_r;
    assign or_a = or_a_r;
    assign or_b = or_b_r;
    assign fast_level_outputs_a = fast_a_r;
    assign fast_level_outputs_b = fast_b_r;
    assign forwarded_data_clock_a = dco_r;
    assign forwarded_data_clock_b = dco_r;
    assign duty_cycle_stabilizer = dcs_r;
    assign reference_on = (state_r != ST_DOWN); // [R4]
    assign core_on = running;
    assign power_state = state_r;
endmodule // dapc_top

// file: dapc_top_properties.sv
// Purpose: Port assertions of dapc_top
// Assumes: Pins pass a two-stage synchroniser before use
// Notes: Five-cycle antecedents cover the synchroniser delay
`timescale 1ns/1ns
module dapc_top_properties (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Pins and controls
    input wire power_down_request,
    input wire serial_io_or_stabilizer_select_pin,
    input wire monitor_out_or_output_disable_pin,
    input wire serial_mode,
    input wire [1:0] serial_power_mode,
    input wire [12:0] reg_addr,
    // Outputs
    input wire [7:0] reg_rdata,
    input wire data_a_oe,
    input wire data_b_oe,
    input wire fast_a_oe,
    input wire fast_b_oe,
    input wire dco_oe,
    input wire duty_cycle_stabilizer,
    input wire reference_on,
    input wire [2:0] power_state
);
    wire [3:0] oe_all = {data_a_oe, data_b_oe, fast_a_oe, fast_b_oe};
    wire sel_reg = reg_addr == 13'h014;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    pin_pd_a: assert property (power_down_request [*5] |-> power_state == 3'h4)
        else $error("pin power-down missed");
    serial_pd_a: assert property (serial_mode && serial_power_mode == 2'h1 |-> ##[1:2] power_state == 3'h4)
        else $error("serial power-down missed");
    down_off_a: assert property (power_state[2] |-> oe_all == 4'h0 && !dco_oe)
        else $error("driver on in power-down");
    pin_resume_a: assert property ((!power_down_request && !serial_mode) [*5] |-> power_state == 3'h1)
        else $error("no resume");
    standby_ref_a: assert property ((serial_mode && serial_power_mode == 2'h2 && !power_down_request) [*5]
        |-> power_state == 3'h2 && reference_on) else $error("standby wrong");
    stab_pin_a: assert property ((!serial_mode && $stable(serial_io_or_stabilizer_select_pin)) [*5]
        |-> duty_cycle_stabilizer == serial_io_or_stabilizer_select_pin) else $error("stabilizer wrong");
    oe_high_a: assert property (monitor_out_or_output_disable_pin [*5] |-> oe_all == 4'h0)
        else $error("drivers on while disabled");
    oe_low_a: assert property ((!monitor_out_or_output_disable_pin) [*5] ##0
        (power_state == 3'h1 && sel_reg && reg_rdata[1:0] == 2'h0) |-> oe_all == 4'hf) else $error("drivers off");
    chan_tri_a: assert property (sel_reg && reg_rdata[0] |-> !data_a_oe && !fast_a_oe)
        else $error("channel a not three-stated");
    unmapped_zero_a: assert property (!sel_reg |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    dco_run_a: assert property (dco_oe == power_state[0])
        else $error("clock enable wrong");
endmodule // dapc_top_properties
bind dapc_top dapc_top_properties dapc_top_properties_i (.mclk, .srst, .power_down_request,
    .serial_io_or_stabilizer_select_pin, .monitor_out_or_output_disable_pin, .serial_mode, .serial_power_mode,
    .reg_addr, .reg_rdata, .data_a_oe, .data_b_oe, .fast_a_oe, .fast_b_oe, .dco_oe, .duty_cycle_stabilizer,
    .reference_on, .power_state);

// file: dapc_capture_model.sv
// Purpose: Downstream capture register fed by the converter
// Assumes: Forwarded clock far slower than mclk
// Notes: Ignores the clock while its driver is off; takes the falling edge when the clock is inverted
`timescale 1ns/1ns
module dapc_capture_model (
    // Clock
    input wire mclk,
    // From converter
    input wire forwarded_data_clock,
    input wire dco_inv,
    input wire dco_oe,
    input wire [23:0] word,
    // Captured result
    output reg cap_stb_r,
    output reg [23:0] cap_word_r
);
    reg dco_r = 1'b0;
    wire launch = dco_oe && (dco_inv ? (!forwarded_data_clock && dco_r) : (forwarded_data_clock && !dco_r));
    initial cap_stb_r = 1'b0;
    always @(posedge mclk) begin
        dco_r <= forwarded_data_clock;
        cap_stb_r <= launch;
        if (launch) begin
            cap_word_r <= word;
        end
    end
endmodule // dapc_capture_model

// file: tb_dapc_top.sv
// Purpose: Self-checking bench of dapc_top
// Assumes: Sample clock of 400 ns, stands high between bursts
// Notes: Each coding mode starts after a power-down so the pipe is empty
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_dapc_top;
    reg mclk = 0, srst = 1, sample_clk = 1, power_down_request = 0, serial_clock_or_format_select_pin = 0;
    reg serial_io_or_stabilizer_select_pin = 1, monitor_out_or_output_disable_pin = 0, serial_mode = 0;
    reg serial_dco_invert = 0, reg_wr = 0, core_or_a = 0, core_or_b = 0, tw = 0, gr = 0;
    reg [1:0] serial_power_mode = 0, serial_format = 0;
    reg [10:0] core_code_a = 0, core_code_b = 0;
    reg [3:0] core_fast_a = 0, core_fast_b = 0;
    reg [12:0] reg_addr = 0;
    reg [7:0] reg_wdata = 0;
    wire [7:0] reg_rdata;
    wire [10:0] data_a, data_b;
    wire [3:0] fast_level_outputs_a, fast_level_outputs_b;
    wire [2:0] power_state;
    wire or_a, or_b, data_a_oe, data_b_oe, fast_a_oe, fast_b_oe, dco_oe, cap_stb_r;
    wire forwarded_data_clock_a, forwarded_data_clock_b, duty_cycle_stabilizer, reference_on, core_on;
    wire [23:0] cap_word_r;
    integer err_count = 0, num_checks = 0, seed = 96569, i, k, n, r;
    reg [23:0] hist [0:17];
    reg [23:0] exp_q [$];
    reg [23:0] ew;
    reg [2:0] fw;
    dapc_top dapc_top_i (.mclk, .srst, .sample_clk, .power_down_request, .serial_clock_or_format_select_pin,
        .serial_io_or_stabilizer_select_pin, .monitor_out_or_output_disable_pin, .core_code_a, .core_or_a,
        .core_fast_a, .core_code_b, .core_or_b, .core_fast_b, .serial_mode, .serial_power_mode, .serial_format,
        .serial_dco_invert, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .data_a, .data_a_oe, .or_a,
        .fast_level_outputs_a, .fast_a_oe, .data_b, .data_b_oe, .or_b, .fast_level_outputs_b, .fast_b_oe,
        .forwarded_data_clock_a, .forwarded_data_clock_b, .dco_oe, .duty_cycle_stabilizer, .reference_on,
        .core_on, .power_state);
    // A released data bus shows the inverse of its last value to the capture side
    dapc_capture_model dapc_capture_model_i (.mclk, .forwarded_data_clock(forwarded_data_clock_a), .dco_inv(serial_dco_invert),
        .dco_oe, .word({data_a_oe ? {data_a, or_a} : ~{data_a, or_a},
        data_b_oe ? {data_b, or_b} : ~{data_b, or_b}}), .cap_stb_r, .cap_word_r);
    initial begin
        forever #25 mclk = ~mclk;
    end
    task cyc(input integer c);
        repeat (c) @(posedge mclk);
        #1;
    endtask
    task wr(input [12:0] a, input [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        cyc(1);
        reg_wr = 0;
        // Idle cycle so back-to-back writes never retoggle the strobe in one step
        cyc(1);
    endtask
    function [10:0] enc(input [10:0] c);
        enc = tw ? c ^ 11'h400 : gr ? c ^ (c >> 1) : c;
    endfunction
    task stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Each capture takes the oldest note; a capture with no note compares against unknown
    always @(posedge mclk) begin
        if (cap_stb_r) begin
            ew = exp_q.size() > 0 ? exp_q.pop_front() : 24'hxxxxxx;
            `CHK("data word", ew, cap_word_r)
        end
    end
    initial begin
        cyc(20000);
        `CHK("timeout", 0, 1)
        stop_test;
    end
    initial begin
        cyc(10);
        srst = 0;
        cyc(2);
        wr(13'h014, 8'h01);
        `CHK("oe a", 3'h4, {data_b_oe, data_a_oe, fast_a_oe})
        wr(13'h015, 8'hff);
        `CHK("unmapped", 8'h00, reg_rdata)
        wr(13'h014, 8'h02);
        `CHK("oe ab", 2'h2, {data_a_oe, data_b_oe})
        wr(13'h014, 8'h00);
        monitor_out_or_output_disable_pin = 1; // Held for cycles, never toggled fast
        cyc(5);
        `CHK("oe pin high", 4'h0, {data_a_oe, data_b_oe, fast_a_oe, fast_b_oe})
        monitor_out_or_output_disable_pin = 0;
        cyc(5);
        `CHK("oe pin low", 4'hf, {data_a_oe, data_b_oe, fast_a_oe, fast_b_oe})
        $display("test regs done");
        serial_mode = 1;
        serial_power_mode = 2'h1;
        cyc(3);
        `CHK("serial down", 4'h4, {dco_oe, power_state})
        serial_power_mode = 2'h2;
        cyc(3);
        `CHK("standby", 4'ha, {reference_on, power_state})
        serial_power_mode = 2'h0;
        serial_mode = 0;
        serial_io_or_stabilizer_select_pin = 0;
        cyc(6);
        `CHK("stabilizer", 4'h1, {duty_cycle_stabilizer, power_state})
        serial_io_or_stabilizer_select_pin = 1;
        $display("test power done");
        for (i = 0; i < 6; i++) begin
            serial_mode = i > 1;
            serial_dco_invert = i == 5;
            serial_clock_or_format_select_pin = i == 1;
            serial_format = i[1:0] - 2'h2;
            tw = i == 1 || i == 3;
            gr = i == 4;
            power_down_request = 1;
            cyc(5);
            `CHK("down", 3'h4, power_state)
            power_down_request = 0;
            for (n = 0; n < 20 && power_state !== 3'h1; n++) cyc(1);
            `CHK("up", 3'h1, power_state)
            cyc(2);
            for (k = 0; k < 18; k++) begin
                sample_clk = 0;
                r = $random(seed);
                {core_or_a, core_code_a, core_or_b, core_code_b} = r[23:0];
                {core_fast_a, core_fast_b} = r[31:24];
                hist[k] = {enc(core_code_a), core_or_a, enc(core_code_b), core_or_b};
                exp_q.push_back(k < 13 ? 24'h0 : hist[k - 13]);
                cyc(4);
                `CHK("data clocks", {i != 5, i != 5}, {forwarded_data_clock_a, forwarded_data_clock_b})
                sample_clk = 1;
                cyc(4);
                `CHK("fast", {core_fast_a, core_fast_b}, {fast_level_outputs_a, fast_level_outputs_b})
                fw = {forwarded_data_clock_a, forwarded_data_clock_b, core_on};
                `CHK("clocks low", {i == 5, i == 5, 1'b1}, fw)
            end
            $display("test mode %0d done", i);
        end
        cyc(8);
        `CHK("pending notes", 0, exp_q.size())
        stop_test;
    end
endmodule // tb_dapc_top
